/* File: pkg/dtf_pkg.sv */
// Constants, codes and state types for the dual drawer feed controller.
// Assumes one clock domain and sensor inputs already synchronous to it.
package dtf_pkg;

  localparam int          DRAWERS       = 2;
  localparam int          UPPER         = 0;
  localparam int          LOWER         = 1;
  localparam int          ADDR_W        = 3;
  localparam int          CMD_W         = 2;
  localparam int          TIMER_W       = 32;

  // Link addressing: units 1 to 5 on one chain.
  localparam logic [2:0]  ADDR_FIRST    = 3'h1;
  localparam logic [2:0]  ADDR_LAST     = 3'h5;

  localparam logic [1:0]  CMD_NOP        = 2'h0;
  localparam logic [1:0]  CMD_FEED_UPPER = 2'h1;
  localparam logic [1:0]  CMD_FEED_LOWER = 2'h2;
  localparam logic [1:0]  CMD_CLEAR      = 2'h3;

  // Size switch patterns, bit 0 is s1 and bit 3 is s4.
  localparam logic [3:0]  SW_LEDGER     = 4'h0;
  localparam logic [3:0]  SW_A3         = 4'h2;
  localparam logic [3:0]  SW_B4         = 4'h1;
  localparam logic [3:0]  SW_LEGAL      = 4'h3;
  localparam logic [3:0]  SW_LETTER_L   = 4'h8;
  localparam logic [3:0]  SW_A4_L       = 4'h4;

  localparam logic [2:0]  SIZE_LEDGER   = 3'h0;
  localparam logic [2:0]  SIZE_A3       = 3'h1;
  localparam logic [2:0]  SIZE_B4       = 3'h2;
  localparam logic [2:0]  SIZE_LEGAL    = 3'h3;
  localparam logic [2:0]  SIZE_LETTER_L = 3'h4;
  localparam logic [2:0]  SIZE_A4_L     = 3'h5;
  localparam logic [2:0]  SIZE_UNKNOWN  = 3'h7;

  // Level codes, higher means fuller.
  localparam logic [1:0]  LEVEL_FULL    = 2'h3;
  localparam logic [1:0]  LEVEL_3Q      = 2'h2;
  localparam logic [1:0]  LEVEL_HALF    = 2'h1;
  localparam logic [1:0]  LEVEL_1Q      = 2'h0;

  localparam logic [31:0] JAM_CYCLES_DEF  = 32'h0098_9680;
  localparam logic [31:0] LIFT_CYCLES_DEF = 32'h02FA_F080;

  typedef enum logic [1:0] {
    FS_IDLE = 2'h0,
    FS_FEED = 2'h1,
    FS_DONE = 2'h3,
    FS_JAM  = 2'h2
  } dtf_feed_t;

  typedef enum logic {
    LS_IDLE  = 1'h0,
    LS_RAISE = 1'h1
  } dtf_lift_t;

endpackage

/* File: src/dtf_controller.sv */
// Dual drawer feed controller: drawer sensing, pickup, jam watch, lift.
// Assumes all inputs are synchronous to REF_CLK and the link is
// a registered, addressed command chain.
`timescale 1ns/1ns
module dtf_controller #(
  parameter logic [31:0] JAM_CYCLES  = dtf_pkg::JAM_CYCLES_DEF,
  parameter logic [31:0] LIFT_CYCLES = dtf_pkg::LIFT_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RESET_N,
  // Supply and unit address strap
  input  wire logic       POWER_ON,
  input  wire logic [2:0] UNIT_ADDR,
  // Drawer sensors
  input  wire logic       UPPER_DRAWER_PRESENT_SENSOR,
  input  wire logic       LOWER_DRAWER_PRESENT_SENSOR,
  input  wire logic       UPPER_PAPER_OUT_SENSOR,
  input  wire logic       LOWER_PAPER_OUT_SENSOR,
  input  wire logic       UPPER_LEVEL_SWITCH_A,
  input  wire logic       UPPER_LEVEL_SWITCH_B,
  input  wire logic       LOWER_LEVEL_SWITCH_A,
  input  wire logic       LOWER_LEVEL_SWITCH_B,
  input  wire logic [3:0] UPPER_SIZE_SWITCH,
  input  wire logic [3:0] LOWER_SIZE_SWITCH,
  input  wire logic [1:0] STACK_CONTACT,
  input  wire logic       TRANSFER_SENSOR_FIRST,
  input  wire logic       TRANSFER_SENSOR_SECOND,
  input  wire logic       MOTOR_FAULT,
  // Link input port
  input  wire logic       CMD_VALID,
  input  wire logic [2:0] CMD_ADDR,
  input  wire logic [1:0] CMD_CODE,
  // Link output port
  output logic            CHAIN_VALID,
  output logic [2:0]      CHAIN_ADDR,
  output logic [1:0]      CHAIN_CODE,
  // Actuators
  output logic            PICKUP_MOTOR_ON,
  output logic            PICKUP_MOTOR_CW,
  output logic            PICKUP_SOLENOID,
  output logic [1:0]      LIFT_SOLENOID,
  // Reports to host
  output logic [1:0]      DRAWER_PRESENT,
  output logic [1:0]      PAPER_PRESENT,
  output logic [1:0]      UPPER_LEVEL,
  output logic [1:0]      LOWER_LEVEL,
  output logic [2:0]      UPPER_SIZE,
  output logic [2:0]      LOWER_SIZE,
  output logic            FEED_DONE,
  output logic            FEED_REFUSED,
  output logic            JAM,
  output logic            FAULT
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] level_of(input logic a, input logic b);
    logic [1:0] l;
    case ({a, b})
      2'h0:    l = dtf_pkg::LEVEL_FULL;
      2'h2:    l = dtf_pkg::LEVEL_3Q;
      2'h3:    l = dtf_pkg::LEVEL_HALF;
      default: l = dtf_pkg::LEVEL_1Q;
    endcase
    return l;
  endfunction

  function automatic logic [2:0] size_of(input logic [3:0] sw);
    logic [2:0] s;
    case (sw)
      dtf_pkg::SW_LEDGER:   s = dtf_pkg::SIZE_LEDGER;
      dtf_pkg::SW_A3:       s = dtf_pkg::SIZE_A3;
      dtf_pkg::SW_B4:       s = dtf_pkg::SIZE_B4;
      dtf_pkg::SW_LEGAL:    s = dtf_pkg::SIZE_LEGAL;
      dtf_pkg::SW_LETTER_L: s = dtf_pkg::SIZE_LETTER_L;
      dtf_pkg::SW_A4_L:     s = dtf_pkg::SIZE_A4_L;
      default:              s = dtf_pkg::SIZE_UNKNOWN;
    endcase
    return s;
  endfunction

  logic [1:0] present_in;
  logic [1:0] paper_in;
  logic [1:0] lifting;
  logic [1:0] lift_timeout;

  assign present_in = {LOWER_DRAWER_PRESENT_SENSOR, UPPER_DRAWER_PRESENT_SENSOR};
  assign paper_in   = {~LOWER_PAPER_OUT_SENSOR, ~UPPER_PAPER_OUT_SENSOR};

  // ---------------------------------------------------------------
  // Status reporting
  // ---------------------------------------------------------------
  logic [1:0] next_present;
  logic [1:0] next_paper;
  logic [1:0] next_up_level;
  logic [1:0] next_lo_level;
  logic [2:0] next_up_size;
  logic [2:0] next_lo_size;

  always_comb begin
    next_present  = present_in;
    next_paper    = paper_in & present_in;
    next_up_level = level_of(UPPER_LEVEL_SWITCH_A, UPPER_LEVEL_SWITCH_B);
    next_lo_level = level_of(LOWER_LEVEL_SWITCH_A, LOWER_LEVEL_SWITCH_B);
    next_up_size  = size_of(UPPER_SIZE_SWITCH);
    next_lo_size  = size_of(LOWER_SIZE_SWITCH);
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DRAWER_PRESENT <= 2'h0;
      PAPER_PRESENT  <= 2'h0;
      UPPER_LEVEL    <= dtf_pkg::LEVEL_1Q;
      LOWER_LEVEL    <= dtf_pkg::LEVEL_1Q;
      UPPER_SIZE     <= dtf_pkg::SIZE_UNKNOWN;
      LOWER_SIZE     <= dtf_pkg::SIZE_UNKNOWN;
    end else begin
      DRAWER_PRESENT <= next_present;
      PAPER_PRESENT  <= next_paper;
      UPPER_LEVEL    <= next_up_level;
      LOWER_LEVEL    <= next_lo_level;
      UPPER_SIZE     <= next_up_size;
      LOWER_SIZE     <= next_lo_size;
    end
  end

  // ---------------------------------------------------------------
  // Link: take own commands, pass the rest for units 1 to 5 down the chain
  // ---------------------------------------------------------------
  logic       addr_ok;
  logic       for_me;
  logic       cmd_feed;
  logic       cmd_clear;
  logic       next_cvalid;
  logic [2:0] next_caddr;
  logic [1:0] next_ccode;

  assign addr_ok   = (UNIT_ADDR >= dtf_pkg::ADDR_FIRST) &&
                     (UNIT_ADDR <= dtf_pkg::ADDR_LAST);
  assign for_me    = CMD_VALID && addr_ok && (CMD_ADDR == UNIT_ADDR);
  assign cmd_feed  = for_me && POWER_ON &&
                     ((CMD_CODE == dtf_pkg::CMD_FEED_UPPER) ||
                      (CMD_CODE == dtf_pkg::CMD_FEED_LOWER));
  assign cmd_clear = for_me && (CMD_CODE == dtf_pkg::CMD_CLEAR);

  always_comb begin
    next_cvalid = CMD_VALID && !for_me &&
                  (CMD_ADDR >= dtf_pkg::ADDR_FIRST) &&
                  (CMD_ADDR <= dtf_pkg::ADDR_LAST);
    next_caddr  = CMD_ADDR;
    next_ccode  = CMD_CODE;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CHAIN_VALID <= 1'b0;
      CHAIN_ADDR  <= 3'h0;
      CHAIN_CODE  <= dtf_pkg::CMD_NOP;
    end else begin
      CHAIN_VALID <= next_cvalid;
      CHAIN_ADDR  <= next_caddr;
      CHAIN_CODE  <= next_ccode;
    end
  end

  // ---------------------------------------------------------------
  // Lift sequence, one per drawer
  // ---------------------------------------------------------------
  genvar d;
  generate
    for (d = 0; d < dtf_pkg::DRAWERS; d++) begin : g_lift
      dtf_pkg::dtf_lift_t          lstate;
      dtf_pkg::dtf_lift_t          next_lstate;
      logic                        was_present;
      logic [dtf_pkg::TIMER_W-1:0] ltimer;
      logic [dtf_pkg::TIMER_W-1:0] next_ltimer;
      logic                        next_lto;
      logic                        lto;

      always_comb begin
        next_lstate = lstate;
        next_ltimer = ltimer;
        next_lto    = 1'b0;
        case (lstate)
          dtf_pkg::LS_IDLE: begin
            next_ltimer = '0;
            // A fresh drawer, or a stack sunk below the roller, is raised.
            if (POWER_ON && present_in[d] &&
                (!was_present || !STACK_CONTACT[d])) begin
              next_lstate = dtf_pkg::LS_RAISE;
            end
          end
          dtf_pkg::LS_RAISE: begin
            next_ltimer = ltimer + 1'b1;
            if (!POWER_ON || !present_in[d] || STACK_CONTACT[d]) begin
              next_lstate = dtf_pkg::LS_IDLE;
            end else if (ltimer >= LIFT_CYCLES - 1'b1) begin
              next_lstate = dtf_pkg::LS_IDLE;
              next_lto    = 1'b1;
            end
          end
          default: next_lstate = dtf_pkg::LS_IDLE;
        endcase
      end

      always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          lstate           <= dtf_pkg::LS_IDLE;
          ltimer           <= '0;
          was_present      <= 1'b0;
          lto              <= 1'b0;
          LIFT_SOLENOID[d] <= 1'b0;
        end else begin
          lstate           <= next_lstate;
          ltimer           <= next_ltimer;
          was_present      <= present_in[d];
          lto              <= next_lto;
          LIFT_SOLENOID[d] <= (next_lstate == dtf_pkg::LS_RAISE);
        end
      end

      assign lifting[d]      = (lstate == dtf_pkg::LS_RAISE);
      assign lift_timeout[d] = lto;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pickup and feed with jam watch
  // ---------------------------------------------------------------
  dtf_pkg::dtf_feed_t          fstate;
  dtf_pkg::dtf_feed_t          next_fstate;
  logic [dtf_pkg::TIMER_W-1:0] ftimer;
  logic [dtf_pkg::TIMER_W-1:0] next_ftimer;
  logic                        seen_first;
  logic                        seen_second;
  logic                        next_seen_first;
  logic                        next_seen_second;
  logic                        src_lower;
  logic                        next_src_lower;
  logic                        want_lower;
  logic                        src_ready;
  logic                        next_done;
  logic                        next_refused;
  logic                        next_jam;
  logic                        next_fault;

  assign want_lower = (CMD_CODE == dtf_pkg::CMD_FEED_LOWER);
  assign src_ready  = present_in[want_lower] && paper_in[want_lower] &&
                      !lifting[want_lower];

  always_comb begin
    next_fstate      = fstate;
    next_ftimer      = ftimer;
    next_seen_first  = seen_first;
    next_seen_second = seen_second;
    next_src_lower   = src_lower;
    next_done        = 1'b0;
    next_refused     = 1'b0;
    next_jam         = JAM;
    case (fstate)
      dtf_pkg::FS_IDLE: begin
        next_ftimer      = '0;
        next_seen_first  = 1'b0;
        next_seen_second = 1'b0;
        if (cmd_feed && src_ready) begin
          next_fstate    = dtf_pkg::FS_FEED;
          next_src_lower = want_lower;
        end else if (cmd_feed) begin
          next_refused   = 1'b1;
        end
      end
      dtf_pkg::FS_FEED: begin
        next_ftimer      = ftimer + 1'b1;
        next_seen_first  = seen_first || TRANSFER_SENSOR_FIRST;
        next_seen_second = seen_second || TRANSFER_SENSOR_SECOND;
        if (next_seen_first && next_seen_second) begin
          next_fstate = dtf_pkg::FS_DONE;
        end else if (ftimer >= JAM_CYCLES - 1'b1) begin
          next_fstate = dtf_pkg::FS_JAM;
        end
      end
      dtf_pkg::FS_DONE: begin
        next_done   = 1'b1;
        next_fstate = dtf_pkg::FS_IDLE;
      end
      dtf_pkg::FS_JAM: begin
        if (cmd_clear) begin
          next_fstate = dtf_pkg::FS_IDLE;
        end
      end
      default: next_fstate = dtf_pkg::FS_IDLE;
    endcase
    // Losing supply mid-feed drops the sheet attempt without a jam.
    if (!POWER_ON && fstate != dtf_pkg::FS_JAM) begin
      next_fstate = dtf_pkg::FS_IDLE;
      next_done   = 1'b0;
    end
    if (cmd_clear) begin
      next_jam = 1'b0;
    end
    if (next_fstate == dtf_pkg::FS_JAM) begin
      next_jam = 1'b1;
    end
    next_fault = FAULT;
    if (cmd_clear) begin
      next_fault = 1'b0;
    end
    if (MOTOR_FAULT || (|lift_timeout)) begin
      next_fault = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fstate          <= dtf_pkg::FS_IDLE;
      ftimer          <= '0;
      seen_first      <= 1'b0;
      seen_second     <= 1'b0;
      src_lower       <= 1'b0;
      PICKUP_MOTOR_ON <= 1'b0;
      PICKUP_MOTOR_CW <= 1'b0;
      PICKUP_SOLENOID <= 1'b0;
      FEED_DONE       <= 1'b0;
      FEED_REFUSED    <= 1'b0;
      JAM             <= 1'b0;
      FAULT           <= 1'b0;
    end else begin
      fstate          <= next_fstate;
      ftimer          <= next_ftimer;
      seen_first      <= next_seen_first;
      seen_second     <= next_seen_second;
      src_lower       <= next_src_lower;
      PICKUP_MOTOR_ON <= (next_fstate == dtf_pkg::FS_FEED);
      PICKUP_MOTOR_CW <= (next_fstate == dtf_pkg::FS_FEED) && !next_src_lower;
      PICKUP_SOLENOID <= (next_fstate == dtf_pkg::FS_FEED);
      FEED_DONE       <= next_done;
      FEED_REFUSED    <= next_refused;
      JAM             <= next_jam;
      FAULT           <= next_fault;
    end
  end

endmodule

/* File: test/dtf_controller_tb.sv */
// Self-checking bench for the dual drawer feed controller.
// Assumes the host model drives the link and supply enable.
`timescale 1ns/1ns
module dtf_controller_tb;
  typedef struct packed {
    logic [3:0] sw;
    logic [2:0] size;
    logic [1:0] ab;
    logic [1:0] lvl;
    logic [1:0] out;
  } dtf_row_t;
  localparam logic [31:0] JAM_C  = 32'h32;
  localparam logic [31:0] LIFT_C = 32'h28;
  logic       REF_CLK, RESET_N, POWER_ON, CMD_VALID, CHAIN_VALID, MOTOR_FAULT;
  logic       UPPER_DRAWER_PRESENT_SENSOR, LOWER_DRAWER_PRESENT_SENSOR;
  logic       UPPER_PAPER_OUT_SENSOR, LOWER_PAPER_OUT_SENSOR, TRANSFER_SENSOR_FIRST;
  logic       UPPER_LEVEL_SWITCH_A, UPPER_LEVEL_SWITCH_B, LOWER_LEVEL_SWITCH_A;
  logic       LOWER_LEVEL_SWITCH_B, TRANSFER_SENSOR_SECOND, PICKUP_MOTOR_ON, PICKUP_MOTOR_CW;
  logic       PICKUP_SOLENOID, FEED_DONE, FEED_REFUSED, JAM, FAULT;
  logic [1:0] CMD_CODE, CHAIN_CODE, STACK_CONTACT, LIFT_SOLENOID, DRAWER_PRESENT;
  logic [1:0] PAPER_PRESENT, UPPER_LEVEL, LOWER_LEVEL;
  logic [2:0] UNIT_ADDR, CMD_ADDR, CHAIN_ADDR, UPPER_SIZE, LOWER_SIZE;
  logic [3:0] UPPER_SIZE_SWITCH, LOWER_SIZE_SWITCH;
  int         errors, comparisons, n;
  dtf_row_t   rows [7] = '{
    '{dtf_pkg::SW_LEDGER, dtf_pkg::SIZE_LEDGER, 2'h0, dtf_pkg::LEVEL_FULL, 2'h0},
    '{dtf_pkg::SW_A3, dtf_pkg::SIZE_A3, 2'h2, dtf_pkg::LEVEL_3Q, 2'h1},
    '{dtf_pkg::SW_B4, dtf_pkg::SIZE_B4, 2'h3, dtf_pkg::LEVEL_HALF, 2'h2},
    '{dtf_pkg::SW_LEGAL, dtf_pkg::SIZE_LEGAL, 2'h1, dtf_pkg::LEVEL_1Q, 2'h3},
    '{dtf_pkg::SW_LETTER_L, dtf_pkg::SIZE_LETTER_L, 2'h0, dtf_pkg::LEVEL_FULL, 2'h0},
    '{dtf_pkg::SW_A4_L, dtf_pkg::SIZE_A4_L, 2'h2, dtf_pkg::LEVEL_3Q, 2'h0},
    '{4'hF, dtf_pkg::SIZE_UNKNOWN, 2'h3, dtf_pkg::LEVEL_HALF, 2'h0}};
  dtf_controller #(.JAM_CYCLES(JAM_C), .LIFT_CYCLES(LIFT_C)) DUT (.*);
  dtf_host_model host (.*);
  // ---------
  // Bench tasks
  // ---------
  task automatic test_done;
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge REF_CLK);
    #1;
  endtask
  task automatic limit(input int k);
    if (k >= 200) begin
      errors++;
      test_done;
    end
  endtask
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  initial begin
    errors = 0;
    comparisons = 0;
    RESET_N = 1'b0;
    UNIT_ADDR = 3'h2;
    {UPPER_DRAWER_PRESENT_SENSOR, LOWER_DRAWER_PRESENT_SENSOR} = 2'h3;
    {UPPER_PAPER_OUT_SENSOR, LOWER_PAPER_OUT_SENSOR, MOTOR_FAULT} = 3'h0;
    {UPPER_LEVEL_SWITCH_A, UPPER_LEVEL_SWITCH_B, LOWER_LEVEL_SWITCH_A, LOWER_LEVEL_SWITCH_B} = 4'h0;
    {UPPER_SIZE_SWITCH, LOWER_SIZE_SWITCH} = 8'h00;
    {TRANSFER_SENSOR_FIRST, TRANSFER_SENSOR_SECOND} = 2'h0;
    STACK_CONTACT = 2'h3;
    repeat (10) tick;
    chk("reset size", {UPPER_SIZE, LOWER_SIZE}, {2{dtf_pkg::SIZE_UNKNOWN}});
    RESET_N = 1'b1;
    repeat (3) tick;
    for (int i = 0; i < 7; i++) begin
      {UPPER_SIZE_SWITCH, LOWER_SIZE_SWITCH} = {2{rows[i].sw}};
      {UPPER_LEVEL_SWITCH_A, UPPER_LEVEL_SWITCH_B} = rows[i].ab;
      {LOWER_LEVEL_SWITCH_A, LOWER_LEVEL_SWITCH_B} = rows[i].ab;
      {LOWER_PAPER_OUT_SENSOR, UPPER_PAPER_OUT_SENSOR} = rows[i].out;
      repeat (2) tick;
      chk("sizes", {UPPER_SIZE, LOWER_SIZE}, {2{rows[i].size}});
      chk("levels", {UPPER_LEVEL, LOWER_LEVEL}, {2{rows[i].lvl}});
      chk("paper", {DRAWER_PRESENT, PAPER_PRESENT}, {2'h3, ~rows[i].out});
    end
    host.send(3'h2, dtf_pkg::CMD_FEED_UPPER);
    chk("upper feed", {PICKUP_MOTOR_ON, PICKUP_MOTOR_CW, PICKUP_SOLENOID}, 3'h7);
    TRANSFER_SENSOR_FIRST = 1'b1;
    tick;
    {TRANSFER_SENSOR_FIRST, TRANSFER_SENSOR_SECOND} = 2'h1;
    for (n = 0; n < 200 && FEED_DONE !== 1'b1; n++) tick;
    limit(n);
    chk("feed end", {PICKUP_MOTOR_ON, PICKUP_SOLENOID, JAM}, 3'h0);
    TRANSFER_SENSOR_SECOND = 1'b0;
    host.send(3'h2, dtf_pkg::CMD_FEED_LOWER);
    chk("lower feed", {PICKUP_MOTOR_ON, PICKUP_MOTOR_CW, PICKUP_SOLENOID}, 3'h5);
    for (n = 0; n < 200 && JAM !== 1'b1; n++) tick;
    limit(n);
    chk("jam halt", {PICKUP_MOTOR_ON, PICKUP_SOLENOID}, 2'h0);
    chk("jam time", n + 2 >= JAM_C && n <= JAM_C + 1, 1'b1);
    host.send(3'h2, dtf_pkg::CMD_FEED_UPPER);
    chk("feed in jam", {PICKUP_MOTOR_ON, FEED_REFUSED, JAM}, 3'h1);
    host.send(3'h2, dtf_pkg::CMD_CLEAR);
    chk("jam clear", JAM, 1'b0);
    UPPER_PAPER_OUT_SENSOR = 1'b1;
    repeat (2) tick;
    host.send(3'h2, dtf_pkg::CMD_FEED_UPPER);
    chk("empty feed", {PICKUP_MOTOR_ON, FEED_REFUSED}, 2'h1);
    UPPER_PAPER_OUT_SENSOR = 1'b0;
    host.send(3'h5, dtf_pkg::CMD_FEED_LOWER);
    chk("forward", {CHAIN_VALID, CHAIN_ADDR, CHAIN_CODE, PICKUP_MOTOR_ON}, 7'h6C);
    host.send(3'h6, dtf_pkg::CMD_NOP);
    chk("beyond chain", CHAIN_VALID, 1'b0);
    MOTOR_FAULT = 1'b1;
    repeat (2) tick;
    chk("fault", FAULT, 1'b1);
    MOTOR_FAULT = 1'b0;
    host.send(3'h2, dtf_pkg::CMD_CLEAR);
    chk("fault clear", FAULT, 1'b0);
    {LOWER_DRAWER_PRESENT_SENSOR, STACK_CONTACT} = 3'h1;
    repeat (3) tick;
    chk("no drawer", LIFT_SOLENOID, 2'h0);
    LOWER_DRAWER_PRESENT_SENSOR = 1'b1;
    repeat (2) tick;
    chk("lift start", LIFT_SOLENOID, 2'h2);
    STACK_CONTACT = 2'h3;
    repeat (3) tick;
    chk("lift stop", LIFT_SOLENOID, 2'h0);
    STACK_CONTACT = 2'h1;
    repeat (3) tick;
    chk("lift again", LIFT_SOLENOID, 2'h2);
    for (n = 0; n < 200 && FAULT !== 1'b1; n++) tick;
    limit(n);
    chk("lift fault", n + 2 >= LIFT_C && n <= LIFT_C + 1, 1'b1);
    STACK_CONTACT = 2'h3;
    repeat (3) tick;
    host.power(1'b0);
    host.send(3'h2, dtf_pkg::CMD_FEED_UPPER);
    chk("power off", {PICKUP_MOTOR_ON, FEED_REFUSED}, 2'h0);
    host.power(1'b1);
    tick;
    test_done;
  end
endmodule

/* File: test/dtf_ctrl_asserts.sv */
// Port-level checks for the dual drawer feed controller.
// Assumes it is bound to dtf_controller and sees only its ports.
`timescale 1ns/1ns
module dtf_ctrl_asserts #(
  parameter logic [31:0] JAM_CYCLES = dtf_pkg::JAM_CYCLES_DEF
) (
  // Clock, reset, supply and link
  input wire logic       REF_CLK,
  input wire logic       RESET_N,
  input wire logic       POWER_ON,
  input wire logic [2:0] UNIT_ADDR,
  input wire logic       CMD_VALID,
  input wire logic [2:0] CMD_ADDR,
  input wire logic [1:0] CMD_CODE,
  input wire logic       CHAIN_VALID,
  input wire logic [2:0] CHAIN_ADDR,
  input wire logic [1:0] CHAIN_CODE,
  // Sensors
  input wire logic       UPPER_DRAWER_PRESENT_SENSOR,
  input wire logic       LOWER_DRAWER_PRESENT_SENSOR,
  input wire logic       UPPER_PAPER_OUT_SENSOR,
  input wire logic       LOWER_PAPER_OUT_SENSOR,
  input wire logic       UPPER_LEVEL_SWITCH_A,
  input wire logic       UPPER_LEVEL_SWITCH_B,
  input wire logic [3:0] UPPER_SIZE_SWITCH,
  input wire logic [1:0] STACK_CONTACT,
  input wire logic       MOTOR_FAULT,
  // Actuators and reports
  input wire logic       PICKUP_MOTOR_ON,
  input wire logic       PICKUP_MOTOR_CW,
  input wire logic       PICKUP_SOLENOID,
  input wire logic [1:0] LIFT_SOLENOID,
  input wire logic [1:0] DRAWER_PRESENT,
  input wire logic [1:0] PAPER_PRESENT,
  input wire logic [1:0] UPPER_LEVEL,
  input wire logic [2:0] UPPER_SIZE,
  input wire logic       FEED_DONE,
  input wire logic       JAM,
  input wire logic       FAULT
);
  // ---------
  // Helpers
  // ---------
  logic [31:0] run_cnt;
  logic [31:0] next_run_cnt;
  logic        take;
  logic        up_ok;
  logic        lo_ok;
  assign take  = CMD_VALID && CMD_ADDR == UNIT_ADDR && UNIT_ADDR >= dtf_pkg::ADDR_FIRST
    && UNIT_ADDR <= dtf_pkg::ADDR_LAST && POWER_ON && !PICKUP_MOTOR_ON && !JAM;
  assign up_ok = UPPER_DRAWER_PRESENT_SENSOR && !UPPER_PAPER_OUT_SENSOR && DRAWER_PRESENT[0]
    && PAPER_PRESENT[0] && STACK_CONTACT[0] && !LIFT_SOLENOID[0];
  assign lo_ok = LOWER_DRAWER_PRESENT_SENSOR && !LOWER_PAPER_OUT_SENSOR && DRAWER_PRESENT[1]
    && PAPER_PRESENT[1] && STACK_CONTACT[1] && !LIFT_SOLENOID[1];
  // Counts consecutive cycles with the pickup motor running.
  always_comb begin
    next_run_cnt = PICKUP_MOTOR_ON ? run_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      run_cnt <= 32'h0;
    end else begin
      run_cnt <= next_run_cnt;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // The cycle right after the motor stops is the done state, which takes no feed.
  a_feed_upper: assert property (take && CMD_CODE == dtf_pkg::CMD_FEED_UPPER && up_ok
    && !$past(PICKUP_MOTOR_ON) |=> PICKUP_MOTOR_ON && PICKUP_MOTOR_CW && PICKUP_SOLENOID)
    else $error("upper feed not started");
  a_feed_lower: assert property (take && CMD_CODE == dtf_pkg::CMD_FEED_LOWER && lo_ok
    && !$past(PICKUP_MOTOR_ON) |=> PICKUP_MOTOR_ON && !PICKUP_MOTOR_CW && PICKUP_SOLENOID)
    else $error("lower feed not started");
  a_sense_track: assert property (1'b1 |=> DRAWER_PRESENT == $past({LOWER_DRAWER_PRESENT_SENSOR,
    UPPER_DRAWER_PRESENT_SENSOR}) && PAPER_PRESENT == $past({LOWER_DRAWER_PRESENT_SENSOR
    && !LOWER_PAPER_OUT_SENSOR, UPPER_DRAWER_PRESENT_SENSOR && !UPPER_PAPER_OUT_SENSOR}))
    else $error("presence report wrong");
  a_level_map: assert property (1'b1 |=> UPPER_LEVEL == {!$past(UPPER_LEVEL_SWITCH_B),
    $past(UPPER_LEVEL_SWITCH_A) == $past(UPPER_LEVEL_SWITCH_B)}) else $error("level code wrong");
  a_size_a3: assert property (UPPER_SIZE_SWITCH == dtf_pkg::SW_A3
    |=> UPPER_SIZE == dtf_pkg::SIZE_A3) else $error("size decode wrong");
  a_jam_bound: assert property (run_cnt <= JAM_CYCLES + 32'h1)
    else $error("feed ran past jam limit");
  a_jam_halt: assert property ($rose(JAM) |-> !PICKUP_MOTOR_ON && !PICKUP_SOLENOID
    && $past(PICKUP_MOTOR_ON)) else $error("jam without halting feed");
  a_done_pulse: assert property (FEED_DONE |-> !PICKUP_MOTOR_ON && !$past(PICKUP_MOTOR_ON)
    && $past(PICKUP_MOTOR_ON, 2)) else $error("done without finished feed");
  a_fault_set: assert property (MOTOR_FAULT |=> FAULT) else $error("fault not reported");
  a_lift_start: assert property ($rose(LOWER_DRAWER_PRESENT_SENSOR) && POWER_ON
    && !STACK_CONTACT[1] |=> LIFT_SOLENOID[1]) else $error("lift not started");
  a_lift_stop: assert property (LIFT_SOLENOID[1] && STACK_CONTACT[1]
    |=> !LIFT_SOLENOID[1]) else $error("lift not stopped");
  a_lift_repeat: assert property (LOWER_DRAWER_PRESENT_SENSOR && POWER_ON && !STACK_CONTACT[1]
    |-> ##[1:2] LIFT_SOLENOID[1]) else $error("lift not repeated");
  a_chain_fwd: assert property (CMD_VALID && POWER_ON && CMD_ADDR != UNIT_ADDR
    && CMD_ADDR >= dtf_pkg::ADDR_FIRST && CMD_ADDR <= dtf_pkg::ADDR_LAST |=> CHAIN_VALID
    && CHAIN_ADDR == $past(CMD_ADDR) && CHAIN_CODE == $past(CMD_CODE)) else $error("not forwarded");
endmodule
bind dtf_controller dtf_ctrl_asserts #(.JAM_CYCLES(JAM_CYCLES)) u_asserts (.*);

/* File: test/dtf_host_model.sv */
// Model of the host paper handling controller on the accessory link.
// Assumes commands are requested by the bench one at a time.
`timescale 1ns/1ns
module dtf_host_model (
  // Clock
  input  wire logic       REF_CLK,
  // Supply enable and link towards the unit
  output logic            POWER_ON,
  output logic            CMD_VALID,
  output logic [2:0]      CMD_ADDR,
  output logic [1:0]      CMD_CODE
);
  initial begin
    POWER_ON  = 1'b1;
    CMD_VALID = 1'b0;
    CMD_ADDR  = 3'h0;
    CMD_CODE  = 2'h0;
  end
  task automatic power(input logic on);
    @(posedge REF_CLK);
    #1;
    POWER_ON = on;
  endtask
  // Idle lines are inverted so a stale command never looks held.
  task automatic send(input logic [2:0] addr, input logic [1:0] code);
    @(posedge REF_CLK);
    #1;
    CMD_VALID = 1'b1;
    CMD_ADDR  = addr;
    CMD_CODE  = code;
    @(posedge REF_CLK);
    #1;
    CMD_VALID = 1'b0;
    CMD_ADDR  = ~addr;
    CMD_CODE  = ~code;
  endtask
endmodule
